// ### design/rom_host_params.svh
`ifndef ROM_HOST_PARAMS_SVH
`define ROM_HOST_PARAMS_SVH
// Bus timing, in ns as the device's slowest grade needs, and derived cycles at 50 MHz
`define CLK_PERIOD_NS 20
`define ACCESS_TIME_NS 250
`define ACCESS_CYCLES ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELEASE_DELAY_NS 60
`define RELEASE_CYCLES ((`RELEASE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_PULSE_NS 100000
`define PROG_PULSE_CYCLES ((`PROG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 13
// Operation codes on the command port
`define OP_READ 3'h0
`define OP_PROGRAM 3'h1
`define OP_VERIFY 3'h2
`define OP_IDENT 3'h3
`define OP_STANDBY 3'h4
`define OP_INHIBIT 3'h5
// Parity bit of an identifier byte
`define TOP_DATA_BIT 7
`endif

// ### design/rom_host_pkg.sv
package rom_host_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_ACCESS,
		ST_PULSE,
		ST_RELEASE
	} phase_e;
endpackage : rom_host_pkg

// ### design/word_latch.sv
// Holds the last word captured from the device; read data come from a register
module word_latch #(
	parameter int W = 16
) (
	input wire logic i_core_clk, // Clock
	input wire logic i_nrst, // Sync reset, low
	input wire logic i_load, // Capture strobe
	input wire logic [W-1:0] i_word, // Word to capture
	output logic [W-1:0] o_word // Stored word
);
	always_ff @(posedge i_core_clk)
	begin
		if (!i_nrst)
			o_word <= '0;
		else if (i_load)
			o_word <= i_word;
	end
endmodule : word_latch

// ### design/rom_host.sv
`include "rom_host_params.svh"
// Overview of operation
// - A normal read has strobe and output gate both low at normal supply level.
// - Programming raises the supply, holds the gate high and pulses the strobe low with data.
// - Verify keeps the supply raised, strobe high and gate low, and reads the contents.
// - Identifier read needs the trigger line high-voltage, strobe and gate low, others low except address bit 0, which picks maker or part.
module rom_host #(
	parameter int AW = 20,
	parameter int DW = 16,
	parameter int PULSE_CYCLES = `PROG_PULSE_CYCLES
) (
	input wire logic i_core_clk, // Clock 50 MHz
	input wire logic i_nrst, // Sync reset, low
	input wire logic i_req, // Command request pulse
	input wire logic [2:0] i_op, // Operation code
	input wire logic [AW-1:0] i_addr, // Location (byte addr in byte mode)
	input wire logic [DW-1:0] i_wdata, // Data to program
	input wire logic i_byte_mode, // 1 selects byte-wide access
	input wire logic [DW-1:0] i_dq, // Device data pins in
	output logic o_busy, // Command in progress
	output logic o_done, // Command finished pulse
	output logic [DW-1:0] o_rdata, // Read result
	output logic o_parity_ok, // Identifier parity odd
	output logic o_strobe_n, // Chip select / program strobe
	output logic o_gate_n, // Output gate
	output logic o_vpp_high, // Raise programming supply
	output logic o_trigger_hv, // Identifier trigger line high voltage
	output logic o_width_word, // Width select, 1 = words
	output logic [AW-1:0] o_addr, // Device address pins
	output logic [DW-1:0] o_dq, // Data pins out
	output logic [DW-1:0] o_dq_oe_n // Data pin enable, low drives
);
	typedef struct packed {
		rom_host_pkg::phase_e phase;
		logic [2:0] op;
		logic [`CNT_W-1:0] cnt;
		logic busy;
		logic done;
		logic strobe_n;
		logic gate_n;
		logic vpp;
		logic trig;
		logic word;
		logic [AW-1:0] addr;
		logic [DW-1:0] dq;
		logic [DW-1:0] oe_n;
		logic par;
	} state_s;

	state_s st_reg;
	state_s st_next;
	logic cap;
	logic [DW-1:0] rd_word;
	logic [DW-1:0] cap_word;

	////////////////////////////////////////////////////////////////////////
	// Byte mode keeps only the low eight lines
	always_comb
	begin
		cap_word = i_dq;
		if (!st_reg.word)
			cap_word = {{(DW-8){1'b0}}, i_dq[7:0]};
	end

	always_comb
	begin
		st_next = st_reg;
		st_next.done = 1'b0;
		cap = 1'b0;
		case (st_reg.phase)
			rom_host_pkg::ST_IDLE:
			begin
				if (i_req)
				begin
					st_next.op = i_op;
					st_next.busy = 1'b1;
					st_next.word = !i_byte_mode;
					st_next.addr = i_addr;
					// Program data is taken with the request, so the host may move on
					st_next.dq = i_wdata;
					st_next.cnt = '0;
					st_next.phase = rom_host_pkg::ST_SETUP;
					st_next.strobe_n = 1'b1;
					st_next.gate_n = 1'b1;
					st_next.trig = 1'b0;
					st_next.vpp = 1'b0;
					case (i_op)
						`OP_PROGRAM, `OP_VERIFY, `OP_INHIBIT:
							st_next.vpp = 1'b1;
						`OP_IDENT:
						begin
							st_next.trig = 1'b1;
							st_next.addr = '0;
							st_next.addr[0] = i_addr[0];
						end
						default:
							st_next.vpp = 1'b0;
					endcase
				end
			end
			rom_host_pkg::ST_SETUP:
			begin
				st_next.cnt = '0;
				st_next.phase = rom_host_pkg::ST_ACCESS;
				case (st_reg.op)
					`OP_READ, `OP_IDENT:
					begin
						st_next.strobe_n = 1'b0;
						st_next.gate_n = 1'b0;
					end
					`OP_PROGRAM:
					begin
						st_next.gate_n = 1'b1;
						st_next.strobe_n = 1'b0;
						st_next.oe_n = '0;
						if (!st_reg.word)
							st_next.oe_n = {{(DW-8){1'b1}}, 8'h00};
						st_next.phase = rom_host_pkg::ST_PULSE;
					end
					`OP_VERIFY:
					begin
						st_next.strobe_n = 1'b1;
						st_next.gate_n = 1'b0;
					end
					default:
					begin
						st_next.strobe_n = 1'b1;
						st_next.gate_n = 1'b1;
						st_next.phase = rom_host_pkg::ST_RELEASE;
					end
				endcase
			end
			rom_host_pkg::ST_ACCESS:
			begin
				st_next.cnt = st_reg.cnt + 1'b1;
				if (st_reg.cnt == `CNT_W'(`ACCESS_CYCLES - 1))
				begin
					cap = 1'b1;
					st_next.par = ^cap_word[7:0];
					st_next.cnt = '0;
					st_next.strobe_n = 1'b1;
					st_next.gate_n = 1'b1;
					st_next.phase = rom_host_pkg::ST_RELEASE;
				end
			end
			rom_host_pkg::ST_PULSE:
			begin
				st_next.cnt = st_reg.cnt + 1'b1;
				if (st_reg.cnt == `CNT_W'(PULSE_CYCLES - 1))
				begin
					st_next.strobe_n = 1'b1;
					st_next.oe_n = '1;
					st_next.cnt = '0;
					st_next.phase = rom_host_pkg::ST_RELEASE;
				end
			end
			rom_host_pkg::ST_RELEASE:
			begin
				st_next.cnt = st_reg.cnt + 1'b1;
				if (st_reg.cnt == `CNT_W'(`RELEASE_CYCLES - 1))
				begin
					st_next.cnt = '0;
					st_next.vpp = 1'b0;
					st_next.trig = 1'b0;
					st_next.busy = 1'b0;
					st_next.done = 1'b1;
					st_next.phase = rom_host_pkg::ST_IDLE;
				end
			end
			default:
				st_next.phase = rom_host_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_nrst)
		begin
			st_reg <= '0;
			st_reg.phase <= rom_host_pkg::ST_IDLE;
			st_reg.strobe_n <= 1'b1;
			st_reg.gate_n <= 1'b1;
			st_reg.word <= 1'b1;
			st_reg.oe_n <= '1;
		end
		else
			st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////
	word_latch #(
		.W(DW)
	) u_latch (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_load(cap),
		.i_word(cap_word),
		.o_word(rd_word)
	);

	assign o_busy = st_reg.busy;
	assign o_done = st_reg.done;
	assign o_rdata = rd_word;
	assign o_parity_ok = st_reg.par;
	assign o_strobe_n = st_reg.strobe_n;
	assign o_gate_n = st_reg.gate_n;
	assign o_vpp_high = st_reg.vpp;
	assign o_trigger_hv = st_reg.trig;
	assign o_width_word = st_reg.word;
	assign o_addr = st_reg.addr;
	assign o_dq = st_reg.dq;
	assign o_dq_oe_n = st_reg.oe_n;

	////////////////////////////////////////////////////////////////////////
	no_drive_while_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(!o_gate_n) |-> (&o_dq_oe_n)) else $error("host drives data while gate low");
	prog_gate_high_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(!(&o_dq_oe_n)) |-> (o_gate_n && o_vpp_high && !o_strobe_n))
		else $error("program drive without program pin state");
	verify_pins_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(o_vpp_high && !o_gate_n) |-> o_strobe_n) else $error("verify with strobe low");
	ident_lines_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		o_trigger_hv |-> (o_addr[AW-1:1] == '0 && !o_vpp_high))
		else $error("identifier read with other lines set");
	release_wait_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		$rose(o_gate_n) |-> !o_done[*2]) else $error("done before output release");
	done_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		o_done |-> (o_strobe_n && o_gate_n && !o_busy)) else $error("done with bus active");
	byte_drive_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(!o_width_word) |-> (&o_dq_oe_n[DW-1:8])) else $error("upper lines driven in byte mode");
	inhibit_pins_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(o_vpp_high && o_strobe_n && o_gate_n) |-> (&o_dq_oe_n))
		else $error("data driven in inhibit");
endmodule : rom_host

// ### test/rom_device_model.sv
module rom_device_model #(
	parameter logic [7:0] MAKER_ID = 8'h07, // Arbitrary
	parameter logic [7:0] PART_ID = 8'h8C // Arbitrary
) (
	input wire logic i_strobe_n, // Strobe
	input wire logic i_gate_n, // Gate
	input wire logic i_vpp_high, // Supply
	input wire logic i_trigger_hv, // Trigger
	input wire logic i_width_word, // Width
	input wire logic [19:0] i_addr, // Address
	input wire logic [15:0] i_dq, // Data
	output logic o_drive, // Driving
	output logic [15:0] o_dq // Data out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:1023] = '{default: 8'hFF};
	logic [9:0] b;
	logic [15:0] val;
	logic [15:0] last = 16'h0;
	always_comb
	begin
		b = i_width_word ? {i_addr[8:0], 1'b0} : i_addr[9:0];
		if (i_trigger_hv && i_addr[19:1] == '0)
			val = {8'h00, i_addr[0] ? PART_ID : MAKER_ID};
		else
			val = i_width_word ? {mem[b + 10'h1], mem[b]} : {8'h00, mem[b]};
		o_drive = !i_gate_n && (!i_strobe_n || i_vpp_high);
	end
	// Released lines show the inverse of the last value
	always @(o_drive or val)
		if (o_drive)
			last <= val;
	assign o_dq = o_drive ? val : ~last;
	// cells written during pulse
	// Pins are looked at once settled: strobe and data enable move in one step
	always @*
	begin
		#1;
		if (!i_strobe_n && i_gate_n && i_vpp_high)
		begin
			mem[b] = i_dq[7:0];
			if (i_width_word)
				mem[b + 10'h1] = i_dq[15:8];
		end
	end
endmodule : rom_device_model

// ### test/testbench.sv
`include "rom_host_params.svh"
`define CHK(nm, e, g) check(nm, (g) !== (e), 32'(e), 32'(g))
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [2:0] op;
		logic [19:0] addr;
		logic [15:0] wdata;
		logic bm;
		logic [15:0] exp;
	} row_s;
	localparam logic [7:0] MAKER = 8'h07; // Arbitrary
	localparam logic [7:0] PART = 8'h8C; // Arbitrary
	localparam int PULSE = 4;
	localparam row_s RD5 = '{`OP_READ, 20'h5, 16'h0, 1'b0, 16'h1234};
	localparam row_s WR0 = '{`OP_PROGRAM, 20'h5, 16'h0, 1'b0, 16'h0};
	localparam row_s WRF = '{`OP_PROGRAM, 20'h64, 16'hFFFF, 1'b0, 16'h0};
	logic i_core_clk = 1'b0, i_nrst = 1'b0, i_req = 1'b0, i_byte_mode = 1'b0;
	logic [2:0] i_op = 3'h0;
	logic [19:0] i_addr = 20'h0;
	logic [15:0] i_wdata = 16'h0;
	logic [15:0] i_dq, o_rdata, o_dq, o_dq_oe_n, dev_dq;
	logic [19:0] o_addr;
	logic o_busy, o_done, o_parity_ok, o_strobe_n, o_gate_n, o_vpp_high, o_trigger_hv;
	logic o_width_word, dev_drive;
	int errors = 0, check_count = 0, cycles = 0;
	int lat = 0, lat_exp = 0;
	row_s rows [10] = '{
		'{`OP_PROGRAM, 20'h5, 16'h1234, 1'b0, 16'h0},
		'{`OP_VERIFY, 20'h5, 16'h0, 1'b0, 16'h1234},
		'{`OP_INHIBIT, 20'h5, 16'h0, 1'b0, 16'h1234},
		'{`OP_READ, 20'h5, 16'h0, 1'b0, 16'h1234},
		'{`OP_PROGRAM, 20'h14, 16'h5A, 1'b1, 16'h1234},
		'{`OP_READ, 20'h14, 16'h0, 1'b1, 16'h5A},
		'{`OP_READ, 20'h15, 16'h0, 1'b1, 16'hFF},
		'{`OP_IDENT, 20'h0, 16'h0, 1'b0, {8'h00, MAKER}},
		'{`OP_IDENT, 20'h1, 16'h0, 1'b0, {8'h00, PART}},
		'{`OP_STANDBY, 20'h0, 16'h0, 1'b0, {8'h00, PART}}
	};
	always #10 i_core_clk = ~i_core_clk;
	assign i_dq = (o_dq & ~o_dq_oe_n) | (dev_dq & o_dq_oe_n);
	rom_host #(.PULSE_CYCLES(PULSE)) i_rom_host (.i_core_clk, .i_nrst, .i_req, .i_op, .i_addr,
		.i_wdata, .i_byte_mode, .i_dq, .o_busy, .o_done, .o_rdata, .o_parity_ok, .o_strobe_n,
		.o_gate_n, .o_vpp_high, .o_trigger_hv, .o_width_word, .o_addr, .o_dq, .o_dq_oe_n);
	rom_device_model #(.MAKER_ID(MAKER), .PART_ID(PART)) i_rom_device_model (
		.i_strobe_n(o_strobe_n), .i_gate_n(o_gate_n), .i_vpp_high(o_vpp_high),
		.i_trigger_hv(o_trigger_hv), .i_width_word(o_width_word), .i_addr(o_addr),
		.i_dq(i_dq), .o_drive(dev_drive), .o_dq(dev_dq));
	task automatic check(input string nm, input logic bad, input logic [31:0] e, g);
		check_count++;
		if (bad)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	// Issues one command and, if asked, waits for its completion pulse
	task automatic run(input row_s r, input bit wt);
		int n;
		n = 0;
		@(posedge i_core_clk);
		i_op <= r.op;
		i_addr <= r.addr;
		i_wdata <= r.wdata;
		i_byte_mode <= r.bm;
		i_req <= 1'b1;
		@(posedge i_core_clk);
		i_req <= 1'b0;
		while (wt && o_done !== 1'b1 && n < 300)
		begin
			@(negedge i_core_clk);
			n++;
		end
		lat = n;
		// A command that never finishes counts as a mismatch
		if (wt && o_done !== 1'b1)
			errors++;
	endtask : run
	always @(negedge i_core_clk)
	begin
		if (dev_drive)
			`CHK("contention", 16'hFFFF, o_dq_oe_n);
		if (!o_strobe_n && o_gate_n)
			`CHK("supply", 1'b1, o_vpp_high);
		if (o_trigger_hv)
			`CHK("ident addr", 19'h0, o_addr[19:1]);
		if (!o_dq_oe_n[0])
			`CHK("prog data", i_wdata[7:0], o_dq[7:0]);
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (10) @(posedge i_core_clk);
		@(negedge i_core_clk);
		`CHK("oe", 16'hFFFF, o_dq_oe_n);
		`CHK("rdata", 16'h0, o_rdata);
		@(posedge i_core_clk);
		i_nrst <= 1'b1;
		$display("reset done");
		for (int k = 0; k < 10; k++)
		begin
			run(rows[k], 1'b1);
			`CHK("rdata", rows[k].exp, o_rdata);
			`CHK("parity", ^rows[k].exp[7:0], o_parity_ok);
			`CHK("width", !rows[k].bm, o_width_word);
			lat_exp = 2 + `RELEASE_CYCLES + `ACCESS_CYCLES;
			if (rows[k].op == `OP_PROGRAM)
				lat_exp = 2 + `RELEASE_CYCLES + PULSE;
			if (rows[k].op == `OP_STANDBY || rows[k].op == `OP_INHIBIT)
				lat_exp = 2 + `RELEASE_CYCLES;
			`CHK("latency", lat_exp, lat);
			$display("row %0d done", k);
		end
		// A request while busy is dropped
		run(RD5, 1'b0);
		run(WR0, 1'b1);
		repeat (3) @(negedge i_core_clk);
		`CHK("busy", 1'b0, o_busy);
		run(RD5, 1'b1);
		`CHK("rdata", 16'h1234, o_rdata);
		$display("refusal done");
		run(WRF, 1'b0);
		repeat (3) @(posedge i_core_clk);
		i_nrst <= 1'b0;
		@(posedge i_core_clk);
		i_nrst <= 1'b1;
		@(negedge i_core_clk);
		`CHK("strobe", 1'b1, o_strobe_n);
		`CHK("supply", 1'b0, o_vpp_high);
		run(RD5, 1'b1);
		`CHK("rdata", 16'h1234, o_rdata);
		$display("midrun reset done");
		tally_and_finish();
	end
endmodule : testbench
